// file: pkg/strap_cfg_pkg.sv
package strap_cfg_pkg;

    // clock and serial memory timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned SCL_HZ = 100_000;
    localparam int unsigned QTR_CYC = CLK_HZ / (4 * SCL_HZ);
    localparam logic [5:0] QTR_LAST = 6'(QTR_CYC - 1);
    localparam logic [1:0] QTR_SAMPLE = 2'h2;
    localparam logic [1:0] QTR_END = 2'h3;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;

    // external port interface modes
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_REV_MII = 2'b01,
        MODE_FWD_MII = 2'b10,
        MODE_SEVEN_WIRE = 2'b11
    } ext_mode_t;

    // straps captured at reset
    typedef struct packed {
        logic glob;
        ext_mode_t mode;
        logic rsv;
        logic cfg_src;
    } strap_t;

    // one byte fetched from the configuration memory
    typedef struct packed {
        logic vld;
        logic [3:0] idx;
        logic [7:0] data;
    } mem_byte_t;

    localparam int NUM_PORTS = 9;
    localparam logic [7:0] PRIO_MAP_RST = 8'hf0;
    localparam logic [2:0] PRIO_LOW_MAX = 3'h3;
    localparam int PORT_EN_BIT = 4;
    localparam int RSV_BIT = 0;
    localparam int RSV_KB = 6;
    localparam logic [15:0] RSV_BYTES = 16'(RSV_KB * 1024);

    // configuration memory layout and bus codes
    localparam logic [3:0] MEM_REG_RSV = 4'h2;
    localparam logic [3:0] MEM_REG_MAP = 4'h3;
    localparam logic [3:0] MEM_REG_PORT0 = 4'h4;
    localparam logic [3:0] MEM_REG_LAST = 4'hc;
    localparam logic [7:0] MEM_DEV_WR = 8'ha0;
    localparam logic [7:0] MEM_DEV_RD = 8'ha1;
    localparam logic [7:0] MEM_START_ADDR = 8'h00;

    // wishbone register byte addresses
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MAP = 8'h04;
    localparam logic [7:0] ADDR_PORT_EN = 8'h08;
    localparam logic [7:0] ADDR_RSV = 8'h0c;

endpackage

// file: design/cfg_mem_loader.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_mem_loader (
    input wire logic clk_i,                        // system clock
    input wire logic rst_i,                        // sync reset, high
    input wire logic start_i,                      // begin the fetch
    input wire logic sda_i,                        // data line level
    output logic scl_o,                            // serial clock out
    output logic sda_o,                            // data drive value
    output logic sda_oe_o,                         // data drive enable
    output strap_cfg_pkg::mem_byte_t byte_o,       // fetched byte
    output logic busy_o,                           // fetch running
    output logic done_o,                           // fetch over
    output logic loaded_o                          // all bytes read
);
    typedef enum logic [2:0] {
        LD_IDLE = 3'b000,
        LD_START = 3'b001,
        LD_TX = 3'b010,
        LD_RX = 3'b011,
        LD_STOP = 3'b100,
        LD_DONE = 3'b101
    } ld_phase_t;

    typedef struct packed {
        ld_phase_t phase;
        logic [5:0] qcnt;
        logic [1:0] qtr;
        logic [3:0] bitn;
        logic [1:0] txsel;
        logic rep;
        logic ok;
        logic loaded;
        logic [7:0] shreg;
        logic [3:0] ridx;
        logic scl;
        logic sda_low;
        strap_cfg_pkg::mem_byte_t outb;
    } ld_state_t;

    ld_state_t q;
    ld_state_t d;
    logic tick;
    logic last_q;
    logic sample;

    assign tick = (q.qcnt == strap_cfg_pkg::QTR_LAST);
    assign last_q = tick && (q.qtr == strap_cfg_pkg::QTR_END);
    assign sample = tick && (q.qtr == strap_cfg_pkg::QTR_SAMPLE);

    // bit engine: four quarters per bit, data moves only while scl is low except at start and stop
    always_comb
    begin
        d = q;
        d.outb.vld = 1'b0;
        if (q.phase != LD_IDLE && q.phase != LD_DONE)
        begin
            d.qcnt = tick ? 6'h00 : q.qcnt + 6'h01;
            d.qtr = tick ? q.qtr + 2'h1 : q.qtr;
        end
        unique case (q.phase)
            LD_IDLE:
            begin
                if (start_i)
                begin
                    d.phase = LD_START;
                    d.rep = 1'b0;
                end
            end
            LD_START:
            begin
                if (last_q)
                begin
                    d.phase = LD_TX;
                    d.bitn = 4'h0;
                    d.shreg = q.rep ? strap_cfg_pkg::MEM_DEV_RD : strap_cfg_pkg::MEM_DEV_WR;
                    d.txsel = q.rep ? 2'h2 : 2'h0;
                end
            end
            LD_TX:
            begin
                if (sample && q.bitn == strap_cfg_pkg::ACK_BIT)
                    d.ok = !sda_i;
                if (last_q && q.bitn == strap_cfg_pkg::ACK_BIT)
                begin
                    d.bitn = 4'h0;
                    // no answer means no memory fitted: give up quietly
                    if (!q.ok)
                        d.phase = LD_STOP;
                    else if (q.txsel == 2'h0)
                    begin
                        d.shreg = strap_cfg_pkg::MEM_START_ADDR;
                        d.txsel = 2'h1;
                    end
                    else if (q.txsel == 2'h1)
                    begin
                        d.phase = LD_START;
                        d.rep = 1'b1;
                    end
                    else
                    begin
                        d.phase = LD_RX;
                        d.ridx = 4'h0;
                    end
                end
                else if (last_q)
                begin
                    d.shreg = {q.shreg[6:0], 1'b0};
                    d.bitn = q.bitn + 4'h1;
                end
            end
            LD_RX:
            begin
                if (sample && q.bitn != strap_cfg_pkg::ACK_BIT)
                    d.shreg = {q.shreg[6:0], sda_i};
                if (last_q && q.bitn == strap_cfg_pkg::LAST_DATA_BIT)
                begin
                    d.outb.vld = 1'b1;
                    d.outb.idx = q.ridx;
                    d.outb.data = q.shreg;
                end
                if (last_q && q.bitn == strap_cfg_pkg::ACK_BIT)
                begin
                    d.bitn = 4'h0;
                    d.ridx = q.ridx + 4'h1;
                    if (q.ridx == strap_cfg_pkg::MEM_REG_LAST)
                    begin
                        d.phase = LD_STOP;
                        d.loaded = 1'b1;
                    end
                end
                else if (last_q)
                    d.bitn = q.bitn + 4'h1;
            end
            LD_STOP:
            begin
                if (last_q)
                    d.phase = LD_DONE;
            end
            LD_DONE:
            begin
                d.phase = LD_DONE;
            end
            default:
            begin
                d.phase = LD_DONE;
            end
        endcase
        // pin levels follow the next state; the line is only pulled low
        d.scl = (d.qtr == 2'h1) || (d.qtr == 2'h2);
        d.sda_low = 1'b0;
        unique case (d.phase)
            LD_START: d.sda_low = d.qtr[1];
            LD_TX: d.sda_low = (d.bitn != strap_cfg_pkg::ACK_BIT) && !d.shreg[7];
            LD_RX: d.sda_low = (d.bitn == strap_cfg_pkg::ACK_BIT) &&
                               (d.ridx != strap_cfg_pkg::MEM_REG_LAST);
            LD_STOP:
            begin
                d.sda_low = !d.qtr[1];
                d.scl = (d.qtr != 2'h0);
            end
            default: d.scl = 1'b1;
        endcase
        if (rst_i)
        begin
            d = '0;
            d.scl = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        q <= d;
    end

    // device owns the clock; data line is shared open-drain
    assign scl_o = q.scl;
    assign sda_o = 1'b0;
    assign sda_oe_o = q.sda_low;
    assign byte_o = q.outb;
    assign busy_o = (q.phase != LD_IDLE) && (q.phase != LD_DONE);
    assign done_o = (q.phase == LD_DONE);
    assign loaded_o = q.loaded;

    // data may only change while the clock is low
    sda_scl_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.phase == LD_TX || q.phase == LD_RX) && $changed(sda_oe_o) |-> !$past(scl_o))
        else $error("data line moved while clock high");

endmodule
`default_nettype wire

// file: design/reset_strap_config_select.sv
// Operation
// - global tag priority strap high enables priority on all ports unless memory disables it.
// - per-port enables from memory bit 4 supersede the global strap.
// - default priority map marks tag values above 3 high, below 4 low.
// - mode 00 off, 01 reverse MII, 10 forward MII, 11 seven-wire serial.
// - reserve strap high sets aside 6 KB for priority traffic, low none.
// - reserve setting from memory register 2 overrides the reserve strap.
// - source strap 0 picks processor, 1 picks serial memory or nothing.
// - device drives serial clock; the single data line is shared with memory.
// - straps are taken only in reset; later pin changes do nothing.
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module reset_strap_config_select (
    input wire logic clk_i,                              // crystal clock in
    input wire logic rst_i,                              // sync reset, high
    input wire logic global_tag_priority_enable_i,       // strap
    input wire logic [1:0] ext_port_mode_select_i,       // strap
    input wire logic priority_buffer_reserve_i,          // strap
    input wire logic config_source_select_i,             // strap
    output logic scl_o,                                  // memory clock
    input wire logic sda_i,                              // memory data in
    output logic sda_o,                                  // memory data out
    output logic sda_oe_o,                               // memory data enable
    input wire logic wb_cyc_i,                           // wishbone cycle
    input wire logic wb_stb_i,                           // wishbone strobe
    input wire logic wb_we_i,                            // wishbone write
    input wire logic [7:0] wb_adr_i,                     // byte address
    input wire logic [3:0] wb_sel_i,                     // byte enables
    input wire logic [31:0] wb_dat_i,                    // write data
    output logic [31:0] wb_dat_o,                        // read data
    output logic wb_ack_o,                               // acknowledge
    input wire logic [2:0] tag_prio_i,                   // frame tag priority
    output logic high_priority_o,                        // class of last tag
    output logic [8:0] port_tag_prio_en_o,               // per-port enable
    output strap_cfg_pkg::ext_mode_t ext_port_mode_o,    // decoded mode
    output logic mii_port_enable_o,                      // mii in use
    output logic reverse_mii_o,                          // acts as phy
    output logic forward_mii_o,                          // acts as mac
    output logic seven_wire_serial_link_o,               // serial link mode
    output logic priority_buffer_reserve_o,              // reserve on
    output logic [15:0] reserved_bytes_o,                // reserved space
    output logic host_if_select_o,                       // processor source
    output logic config_ready_o                          // settings final
);
    typedef struct packed {
        strap_cfg_pkg::strap_t strap;
        logic started;
        logic [7:0] map;
        logic [8:0] port_val;
        logic port_set;
        logic rsv_val;
        logic rsv_set;
        logic high_prio;
        logic ack;
        logic [31:0] rdat;
    } cfg_state_t;

    cfg_state_t q;
    cfg_state_t d;
    strap_cfg_pkg::mem_byte_t mem_byte;
    logic ld_busy;
    logic ld_done;
    logic ld_loaded;
    logic ld_start;
    logic req;
    logic [3:0] port_idx;

    // fetch only when the serial memory is the chosen source
    assign ld_start = q.started == 1'b0 && q.strap.cfg_src;
    assign req = wb_cyc_i && wb_stb_i && !q.ack;
    assign port_idx = mem_byte.idx - strap_cfg_pkg::MEM_REG_PORT0;

    cfg_mem_loader loader (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(ld_start),
        .sda_i(sda_i),
        .scl_o(scl_o),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o),
        .byte_o(mem_byte),
        .busy_o(ld_busy),
        .done_o(ld_done),
        .loaded_o(ld_loaded)
    );

    // next state: straps, memory overrides, register bus, classifier
    always_comb
    begin
        d = q;
        d.started = 1'b1;
        // memory bytes override the latched straps
        if (mem_byte.vld)
        begin
            if (mem_byte.idx == strap_cfg_pkg::MEM_REG_RSV)
            begin
                d.rsv_val = mem_byte.data[strap_cfg_pkg::RSV_BIT];
                d.rsv_set = 1'b1;
            end
            else if (mem_byte.idx == strap_cfg_pkg::MEM_REG_MAP)
                d.map = mem_byte.data;
            else if (mem_byte.idx >= strap_cfg_pkg::MEM_REG_PORT0)
            begin
                d.port_val[port_idx] = mem_byte.data[strap_cfg_pkg::PORT_EN_BIT];
                d.port_set = 1'b1;
            end
        end
        // single-cycle slave: ack one edge after the strobe, unmapped reads zero
        d.ack = req;
        d.rdat = 32'h0000_0000;
        if (req && wb_we_i)
        begin
            // a processor write lands after a same-cycle memory byte, so it wins
            unique case (wb_adr_i)
                strap_cfg_pkg::ADDR_MAP:
                    if (wb_sel_i[0])
                        d.map = wb_dat_i[7:0];
                strap_cfg_pkg::ADDR_PORT_EN:
                begin
                    if (wb_sel_i[0])
                        d.port_val[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1])
                        d.port_val[8] = wb_dat_i[8];
                    d.port_set = q.port_set || wb_sel_i[0] || wb_sel_i[1];
                end
                strap_cfg_pkg::ADDR_RSV:
                    if (wb_sel_i[0])
                    begin
                        d.rsv_val = wb_dat_i[0];
                        d.rsv_set = 1'b1;
                    end
                default:
                begin
                    d.ack = req;
                end
            endcase
        end
        else if (req)
        begin
            unique case (wb_adr_i)
                strap_cfg_pkg::ADDR_STATUS:
                    d.rdat = {24'h00_0000, ld_loaded, config_ready_o, ld_busy,
                              q.strap.cfg_src, priority_buffer_reserve_o,
                              q.strap.glob, q.strap.mode};
                strap_cfg_pkg::ADDR_MAP: d.rdat = {24'h00_0000, q.map};
                strap_cfg_pkg::ADDR_PORT_EN: d.rdat = {23'h00_0000, port_tag_prio_en_o};
                strap_cfg_pkg::ADDR_RSV: d.rdat = {31'h0000_0000, priority_buffer_reserve_o};
                default: d.rdat = 32'h0000_0000;
            endcase
        end
        // class via the map; the default map splits at 3 and 4
        d.high_prio = q.map[tag_prio_i];
        // pins are read only while reset is held
        if (rst_i)
        begin
            d = '0;
            d.map = strap_cfg_pkg::PRIO_MAP_RST;
            d.strap.glob = global_tag_priority_enable_i;
            d.strap.mode = strap_cfg_pkg::ext_mode_t'(ext_port_mode_select_i);
            d.strap.rsv = priority_buffer_reserve_i;
            d.strap.cfg_src = config_source_select_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        q <= d;
    end

    // per-port enable: memory or software bit, else the global strap
    genvar i;
    generate
        for (i = 0; i < strap_cfg_pkg::NUM_PORTS; i++)
        begin : g_port
            assign port_tag_prio_en_o[i] = q.port_set ? q.port_val[i] : q.strap.glob;
        end
    endgenerate

    // mode decode straight from the latched strap
    assign ext_port_mode_o = q.strap.mode;
    assign mii_port_enable_o = (q.strap.mode != strap_cfg_pkg::MODE_OFF);
    assign reverse_mii_o = (q.strap.mode == strap_cfg_pkg::MODE_REV_MII);
    assign forward_mii_o = (q.strap.mode == strap_cfg_pkg::MODE_FWD_MII);
    assign seven_wire_serial_link_o = (q.strap.mode == strap_cfg_pkg::MODE_SEVEN_WIRE);
    // reserve: memory or software value beats the strap
    assign priority_buffer_reserve_o = q.rsv_set ? q.rsv_val : q.strap.rsv;
    assign reserved_bytes_o = priority_buffer_reserve_o ? strap_cfg_pkg::RSV_BYTES : 16'h0000;
    assign host_if_select_o = !q.strap.cfg_src;
    assign config_ready_o = q.started && !ld_busy && (ld_done || !q.strap.cfg_src);
    assign high_priority_o = q.high_prio;
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdat;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    strap_capture_a: assert property ($fell(rst_i) |->
        ext_port_mode_o == $past(ext_port_mode_select_i) &&
        host_if_select_o == !$past(config_source_select_i))
        else $error("straps not taken at reset release");
    strap_hold_a: assert property (!$past(rst_i) |->
        $stable(ext_port_mode_o) && $stable(host_if_select_o) && $stable(q.strap.glob))
        else $error("strap value moved outside reset");
    global_enable_a: assert property (!q.port_set |->
        port_tag_prio_en_o == {strap_cfg_pkg::NUM_PORTS{q.strap.glob}})
        else $error("port enables do not follow global strap");
    port_override_a: assert property (mem_byte.vld && mem_byte.idx == 4'h4 && !req |=>
        port_tag_prio_en_o[0] == $past(mem_byte.data[4]))
        else $error("memory port enable not applied");
    default_class_a: assert property (q.map == 8'hf0 |=>
        high_priority_o == ($past(tag_prio_i) > 3'h3))
        else $error("default priority split wrong");
    mode_decode_a: assert property (
        seven_wire_serial_link_o == (ext_port_mode_o == 2'b11) &&
        reverse_mii_o == (ext_port_mode_o == 2'b01) &&
        mii_port_enable_o == (ext_port_mode_o != 2'b00))
        else $error("mode decode wrong");
    reserve_size_a: assert property (!q.rsv_set |->
        reserved_bytes_o == (q.strap.rsv ? 16'h1800 : 16'h0000))
        else $error("reserve size wrong");
    reserve_override_a: assert property (mem_byte.vld && mem_byte.idx == 4'h2 && !req |=>
        priority_buffer_reserve_o == $past(mem_byte.data[0]))
        else $error("memory reserve not applied");
    host_quiet_a: assert property (host_if_select_o |-> scl_o && !sda_oe_o)
        else $error("serial pins used in processor mode");
    bus_ack_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

endmodule
`default_nettype wire

// file: dv/cfg_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_mem_model (
    input wire logic scl_i, // memory clock
    input wire logic sda_i, // wire level
    input wire logic nak_i, // refuse all bytes
    output logic sda_oe_o // pulls wire low
);
    logic [7:0] mem [13];
    logic [7:0] sh;
    logic [7:0] cur;
    logic [3:0] ptr;
    logic act;
    logic rd;
    logic go_rd;
    logic mack;
    int bc;
    int nb;
    // reserve on, map 0f, even ports enabled
    initial
    begin
        for (int k = 0; k < 13; k++)
            mem[k] = (k > 3 && k % 2 == 0) ? 8'h10 : 8'h00;
        mem[2] = 8'h01;
        mem[3] = 8'h0f;
        sda_oe_o = 1'b0;
        act = 1'b0;
    end
    // start and stop are wire edges while the clock is high
    always @(negedge sda_i)
    begin
        if (scl_i)
        begin
            act = 1'b1;
            bc = 0;
            nb = 0;
            rd = 1'b0;
            go_rd = 1'b0;
        end
    end
    always @(posedge sda_i)
    begin
        if (scl_i)
            act = 1'b0;
    end
    always @(posedge scl_i)
    begin
        if (bc < 8)
            sh = {sh[6:0], sda_i};
        else
            mack = !sda_i;
        bc = bc + 1;
    end
    // the wire only moves while the clock is low
    always @(negedge scl_i)
    begin
        sda_oe_o = 1'b0;
        if (act && bc == 8 && !rd)
        begin
            sda_oe_o = !nak_i;
            go_rd = sh[0] && nb == 0;
            if (nb == 1)
                ptr = sh[3:0];
            nb = nb + 1;
        end
        else if (act && bc == 9)
        begin
            bc = 0;
            if (rd && mack)
                ptr = ptr + 4'h1;
            if (go_rd || (rd && mack))
            begin
                rd = 1'b1;
                go_rd = 1'b0;
                cur = mem[ptr];
                sda_oe_o = !cur[7];
            end
        end
        else if (act && rd && bc < 8)
            sda_oe_o = !cur[7 - bc];
    end
endmodule
`default_nettype wire

// file: dv/reset_strap_config_select_test.sv
`timescale 1ns/1ps
`default_nettype none
module reset_strap_config_select_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic glob = 1'b0;
    logic [1:0] mode = 2'h0;
    logic rsv = 1'b0;
    logic src = 1'b0;
    logic nak = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [2:0] tag = 3'h0;
    logic [31:0] q;
    logic [7:0] r;
    logic [7:0] rows [4] = '{8'hc0, 8'h1c, 8'haa, 8'h79};
    int n_errors = 0;
    int check_count = 0;
    wire logic scl, sda_o, dut_oe, mem_oe, ack, hi, mii, rev, fwd, sev, rsv_o, host, rdy;
    wire logic [31:0] rdat;
    wire logic [8:0] port_en;
    wire logic [15:0] bytes;
    wire strap_cfg_pkg::ext_mode_t ext_mode;
    // open drain with pull-up
    wire logic sda = !(dut_oe || mem_oe);
    always #25 clk_i = !clk_i;
    reset_strap_config_select i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .global_tag_priority_enable_i(glob), .ext_port_mode_select_i(mode),
        .priority_buffer_reserve_i(rsv), .config_source_select_i(src), .scl_o(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_o(dut_oe), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .tag_prio_i(tag), .high_priority_o(hi), .port_tag_prio_en_o(port_en),
        .ext_port_mode_o(ext_mode), .mii_port_enable_o(mii), .reverse_mii_o(rev),
        .forward_mii_o(fwd), .seven_wire_serial_link_o(sev), .priority_buffer_reserve_o(rsv_o),
        .reserved_bytes_o(bytes), .host_if_select_o(host), .config_ready_o(rdy));
    cfg_mem_model i_mem (.scl_i(scl), .sda_i(sda), .nak_i(nak), .sda_oe_o(mem_oe));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // s = {glob, rsv, src, mode}; pins flip after release to prove they are ignored
    task automatic boot(input logic [4:0] s, input logic n);
        rst_i <= 1'b1;
        {glob, rsv, src, mode} <= s;
        nak <= n;
        repeat (10) @(posedge clk_i);
        chk("idle", 32'h1, {31'h0, scl && !dut_oe});
        rst_i <= 1'b0;
        @(posedge clk_i);
        {glob, rsv, src, mode} <= ~s;
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 40000)
        begin
            @(posedge clk_i);
            n++;
        end
        chk("config_ready", 32'h1, {31'h0, rdy});
    endtask
    // waits for ack as long as it takes; only the watchdog ends a hung transfer
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1)
        begin
            @(posedge clk_i);
        end
        q = rdat;
        chk("ack", 32'h1, {31'h0, ack});
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask
    // class shows one edge after the tag is presented; the check waits two
    task automatic classify(input logic [7:0] m);
        for (int t = 0; t < 8; t++)
        begin
            tag <= 3'(t);
            repeat (2) @(posedge clk_i);
            chk("high_priority", {31'h0, m[t]}, {31'h0, hi});
        end
    endtask
    // watchdog: one full memory fetch is about 30k cycles, so twice that is ample
    initial
    begin
        #(60000 * 50);
        n_errors++;
        final_report();
    end
    initial
    begin
        // row = {glob, rsv, mode, mii, rev, fwd, seven}
        for (int i = 0; i < 4; i++)
        begin
            r = rows[i];
            boot({r[7:6], 1'b0, r[5:4]}, 1'b0);
            wait_rdy();
            chk("mode", {30'h0, r[5:4]}, {30'h0, ext_mode});
            chk("decode", {28'h0, r[3:0]}, {28'h0, mii, rev, fwd, sev});
            chk("reserve", {31'h0, r[6]}, {31'h0, rsv_o});
            chk("bytes", r[6] ? 32'h1800 : 32'h0, {16'h0, bytes});
            chk("port_en", r[7] ? 32'h1ff : 32'h0, {23'h0, port_en});
            chk("host", 32'h1, {31'h0, host});
            wb(1'b0, strap_cfg_pkg::ADDR_STATUS, 32'h0);
            chk("status", {24'h0, 2'h1, 1'b0, 1'b0, r[6], r[7], r[5:4]}, q);
            classify(8'hf0);
        end
        // register overrides and an unmapped place
        wb(1'b1, strap_cfg_pkg::ADDR_PORT_EN, 32'h0fe);
        chk("port_en", 32'h0fe, {23'h0, port_en});
        wb(1'b1, strap_cfg_pkg::ADDR_RSV, 32'h0);
        chk("bytes", 32'h0, {16'h0, bytes});
        wb(1'b1, 8'h10, 32'hff);
        wb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, q);
        wb(1'b0, strap_cfg_pkg::ADDR_MAP, 32'h0);
        chk("map", 32'hf0, q);
        wb(1'b1, strap_cfg_pkg::ADDR_MAP, 32'h3c);
        classify(8'h3c);
        // memory contents override the straps
        boot(5'b10110, 1'b0);
        wait_rdy();
        chk("host", 32'h0, {31'h0, host});
        chk("reserve", 32'h1, {31'h0, rsv_o});
        chk("port_en", 32'h155, {23'h0, port_en});
        chk("sda_o", 32'h0, {31'h0, sda_o});
        wb(1'b0, strap_cfg_pkg::ADDR_STATUS, 32'h0);
        chk("status", 32'hde, q);
        classify(8'h0f);
        // refused memory leaves the straps standing
        boot(5'b11111, 1'b1);
        wait_rdy();
        chk("port_en", 32'h1ff, {23'h0, port_en});
        chk("reserve", 32'h1, {31'h0, rsv_o});
        wb(1'b0, strap_cfg_pkg::ADDR_STATUS, 32'h0);
        chk("status", 32'h5f, q);
        classify(8'hf0);
        final_report();
    end
endmodule
`default_nettype wire
